// ==== pkg/eil_pkg.sv ====
// package for the external interrupt latch: register map, field layout, types
package eil_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register indices (byte addresses on the plain register port)
  localparam logic [ADDR_W-1:0] EXT_INT_STATUS_CONTROL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] SYSTEM_CONFIG_TWO_ADDR = 8'h1e;
  localparam logic [ADDR_W-1:0] BREAK_FLAG_CONTROL_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 8'h02;
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 8'h03;

  // status and control field positions
  localparam int MODE_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int PEND_BIT = 3;
  // configuration field positions
  localparam int PUD_BIT = 0;
  localparam int BREAK_CLEAR_ENABLE_BIT = 7;
  // event status / mask field positions
  localparam int EVT_LATCH_BIT = 0;
  localparam int EVT_ACK_BIT = 1;
  localparam int EVT_W = 2;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [EVT_W-1:0] EVT_ZERO = 2'h0;

  typedef enum logic [0:0] {
    EIL_EDGE_ONLY = 1'b0,
    EIL_EDGE_LEVEL = 1'b1
  } eil_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } eil_bus_req_type;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic latch;
    eil_mode_type mode;
    logic mask;
    logic pullup_dis;
    logic break_clear_enable;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic [DATA_W-1:0] rdata;
  } eil_state_type;

  localparam eil_state_type EIL_RESET = '{
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    pin_prev: 1'b1,
    latch: 1'b0,
    mode: EIL_EDGE_ONLY,
    mask: 1'b0,
    pullup_dis: 1'b0,
    break_clear_enable: 1'b0,
    evt_status: 2'h0,
    evt_mask: 2'h0,
    rdata: 8'h00
  };

endpackage

// ==== logic/eil_ext_int_latch.sv ====
// external interrupt latch with edge or edge-and-level sensitivity and register port
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

module eil_ext_int_latch
  import eil_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic int_pin_n_i,
  input wire logic vector_fetch_ack_i,
  input wire logic break_state_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic cpu_irq_req_o,
  output logic pin_pullup_en_o,
  output logic evt_irq_o
);

  eil_state_type state_reg;
  eil_state_type state_next;
  eil_bus_req_type bus;

  // register port decode, one select per mapped register
  logic hit_scr;
  logic hit_cfg;
  logic hit_brk;
  logic hit_evs;
  logic hit_evm;
  logic wr_scr;
  logic wr_cfg;
  logic wr_brk;
  logic wr_evs;
  logic wr_evm;
  logic rd_scr;
  logic rd_cfg;
  logic rd_brk;
  logic rd_evs;
  logic rd_evm;

  // pin path after the two-flop synchroniser
  logic pin_sync;
  logic pin_hist;
  logic pin_low;
  logic falling_edge;

  // acknowledge path
  logic ack_bit_written;
  logic break_blocks_ack;
  logic sw_ack;
  logic hw_ack;
  logic ack_any;

  // latch update terms
  logic latch_clr;
  logic latch_set;
  logic latch_next;

  // request path
  logic level_mode;
  logic level_hold;
  logic pend;
  logic masked;
  logic irq_req;

  // control register write values
  eil_mode_type mode_wval;
  logic mask_wval;
  logic pud_wval;
  logic break_clear_enable_wval;
  logic [EVT_W-1:0] evm_wval;

  // event path
  logic [EVT_W-1:0] evt_clear;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_next;
  logic [EVT_W-1:0] evt_active;

  // read-back words
  logic [DATA_W-1:0] scr_word;
  logic [DATA_W-1:0] cfg_word;
  logic [DATA_W-1:0] brk_word;
  logic [DATA_W-1:0] evs_word;
  logic [DATA_W-1:0] evm_word;
  logic [DATA_W-1:0] rd_word;

  assign bus = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  assign hit_scr = (bus.addr == EXT_INT_STATUS_CONTROL_ADDR);
  assign hit_cfg = (bus.addr == SYSTEM_CONFIG_TWO_ADDR);
  assign hit_brk = (bus.addr == BREAK_FLAG_CONTROL_ADDR);
  assign hit_evs = (bus.addr == EVT_STATUS_ADDR);
  assign hit_evm = (bus.addr == EVT_MASK_ADDR);

  assign wr_scr = bus.wr & hit_scr;
  assign wr_cfg = bus.wr & hit_cfg;
  assign wr_brk = bus.wr & hit_brk;
  assign wr_evs = bus.wr & hit_evs;
  assign wr_evm = bus.wr & hit_evm;

  assign rd_scr = bus.rd & hit_scr;
  assign rd_cfg = bus.rd & hit_cfg;
  assign rd_brk = bus.rd & hit_brk;
  assign rd_evs = bus.rd & hit_evs;
  assign rd_evm = bus.rd & hit_evm;

  // only the second stage and the history flop are read, never the first stage
  assign pin_sync = state_reg.pin_s2;
  assign pin_hist = state_reg.pin_prev;
  assign pin_low = ~pin_sync;
  assign falling_edge = pin_hist & pin_low;

  assign ack_bit_written = wr_scr & bus.wdata[ACK_BIT];
  // break protects the latch from the software acknowledge unless software clearing is enabled
  assign break_blocks_ack = break_state_i & ~state_reg.break_clear_enable;
  assign sw_ack = ack_bit_written & ~break_blocks_ack;
  // the cpu vector fetch is not gated by break
  assign hw_ack = vector_fetch_ack_i;
  assign ack_any = hw_ack | sw_ack;

  // a new edge in the acknowledge cycle wins, so no request is lost
  assign latch_clr = ack_any;
  assign latch_set = falling_edge;
  assign latch_next = latch_set | (state_reg.latch & ~latch_clr);

  assign level_mode = (state_reg.mode == EIL_EDGE_LEVEL);
  assign level_hold = level_mode & pin_low;
  assign pend = state_reg.latch | level_hold;
  assign masked = state_reg.mask;
  assign irq_req = pend & ~masked;

  assign mode_wval = eil_mode_type'(bus.wdata[MODE_BIT]);
  assign mask_wval = bus.wdata[MASK_BIT];
  assign pud_wval = bus.wdata[PUD_BIT];
  assign break_clear_enable_wval = bus.wdata[BREAK_CLEAR_ENABLE_BIT];
  assign evm_wval = bus.wdata[EVT_W-1:0];

  assign evt_clear = wr_evs ? bus.wdata[EVT_W-1:0] : EVT_ZERO;
  assign evt_active = state_reg.evt_status & state_reg.evt_mask;

  always_comb begin
    state_next = state_reg;
    evt_set = EVT_ZERO;
    evt_next = EVT_ZERO;
    scr_word = ZERO_BYTE;
    cfg_word = ZERO_BYTE;
    brk_word = ZERO_BYTE;
    evs_word = ZERO_BYTE;
    evm_word = ZERO_BYTE;
    rd_word = ZERO_BYTE;

    // first stage feeds only the second stage
    state_next.pin_s1 = int_pin_n_i;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_prev = state_reg.pin_s2;

    state_next.latch = latch_next;

    if (wr_scr) begin
      state_next.mode = mode_wval;
      state_next.mask = mask_wval;
    end else if (wr_cfg) begin
      state_next.pullup_dis = pud_wval;
    end else if (wr_brk) begin
      state_next.break_clear_enable = break_clear_enable_wval;
    end else if (wr_evm) begin
      state_next.evt_mask = evm_wval;
    end

    // event bits: a set in the same cycle as the clear wins
    evt_set[EVT_LATCH_BIT] = falling_edge;
    evt_set[EVT_ACK_BIT] = ack_any;
    evt_next = (state_reg.evt_status & ~evt_clear) | evt_set;
    state_next.evt_status = evt_next;

    scr_word[MODE_BIT] = state_reg.mode;
    scr_word[MASK_BIT] = state_reg.mask;
    // acknowledge position is never set, so it reads zero
    scr_word[PEND_BIT] = pend;
    cfg_word[PUD_BIT] = state_reg.pullup_dis;
    brk_word[BREAK_CLEAR_ENABLE_BIT] = state_reg.break_clear_enable;
    evs_word[EVT_W-1:0] = state_reg.evt_status;
    evm_word[EVT_W-1:0] = state_reg.evt_mask;

    // unmapped reads return zero; data stands for one cycle only
    if (rd_scr) begin
      rd_word = scr_word;
    end else if (rd_cfg) begin
      rd_word = cfg_word;
    end else if (rd_brk) begin
      rd_word = brk_word;
    end else if (rd_evs) begin
      rd_word = evs_word;
    end else if (rd_evm) begin
      rd_word = evm_word;
    end
    state_next.rdata = rd_word;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= EIL_RESET;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  // a level-mode request is combinational off synchronised state, so it drops
  // the cycle the pin is seen high if the latch was already acknowledged
  assign cpu_irq_req_o = irq_req;
  assign pin_pullup_en_o = ~state_reg.pullup_dis;
  assign evt_irq_o = |evt_active;
  assign reg_rdata_o = state_reg.rdata;

endmodule

// ==== testbench/eil_props.sv ====
// port checker for the external interrupt latch
`timescale 1ns/1ps
module eil_props
  import eil_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic int_pin_n_i,
  input wire logic vector_fetch_ack_i,
  input wire logic break_state_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic cpu_irq_req_o,
  input wire logic pin_pullup_en_o
);
  logic m, mo, bc;
  logic [3:0] ph;
  wire w0 = reg_wr_i && reg_addr_i == EXT_INT_STATUS_CONTROL_ADDR;
  wire ak = w0 && reg_wdata_i[ACK_BIT];
  // quiet pin: no edge can still be in flight through the synchroniser
  wire qt = {ph, int_pin_n_i} == 5'h00 || {ph, int_pin_n_i} == 5'h1f;
  always_ff @(posedge ref_clk_i) begin
    ph <= {ph[2:0], int_pin_n_i};
    if (!rst_n_i) {bc, m, mo} <= 3'h0;
    else begin
      if (w0) {m, mo} <= reg_wdata_i[1:0];
      if (reg_wr_i && reg_addr_i == BREAK_FLAG_CONTROL_ADDR) bc <= reg_wdata_i[BREAK_CLEAR_ENABLE_BIT];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_fall_sets_req:
    assert property ($fell(int_pin_n_i) && !m |-> ##3 cpu_irq_req_o) else $error("fall lost");
  a_vfetch_clears:
    assert property (vector_fetch_ack_i && !mo && qt |=> !cpu_irq_req_o) else $error("fetch kept");
  a_swack_clears:
    assert property (ak && !mo && qt && !(break_state_i && !bc) && !reg_wdata_i[MODE_BIT]
      |=> !cpu_irq_req_o)
      else $error("ack kept");
  a_break_keeps:
    assert property (ak && break_state_i && !bc && cpu_irq_req_o && !vector_fetch_ack_i
      && !reg_wdata_i[MASK_BIT] && reg_wdata_i[MODE_BIT] == mo |=> cpu_irq_req_o)
      else $error("break ack cleared");
  a_level_pends:
    assert property (mo && !m && {ph[1:0], int_pin_n_i} == 3'h0 |-> cpu_irq_req_o)
      else $error("level lost");
  a_mask_blocks:
    assert property (m |-> !cpu_irq_req_o) else $error("masked request");
  a_pullup_cfg:
    assert property (reg_wr_i && reg_addr_i == SYSTEM_CONFIG_TWO_ADDR
      |=> pin_pullup_en_o != $past(reg_wdata_i[PUD_BIT])) else $error("pullup wrong");
  a_pend_flag:
    assert property ($past(reg_rd_i && reg_addr_i == EXT_INT_STATUS_CONTROL_ADDR && !m)
      |-> reg_rdata_o[PEND_BIT] == $past(cpu_irq_req_o)) else $error("pending wrong");
endmodule
bind eil_ext_int_latch eil_props i_props (.*);

// ==== testbench/eil_src_model.sv ====
// pin source and cpu vector fetch model
`timescale 1ns/1ps
module eil_src_model (
  input wire logic ref_clk_i,
  input wire logic pull_en_i,
  input wire logic low_i,
  input wire logic irq_i,
  input wire logic take_i,
  output logic pin_n_o,
  output logic vfa_o
);
  logic flt = 1'b0;
  // undriven pin without pull-up wanders instead of holding
  always @(posedge ref_clk_i) begin
    flt <= ~flt;
    vfa_o <= take_i & irq_i;
  end
  assign pin_n_o = low_i ? 1'b0 : pull_en_i ? 1'b1 : flt;
endmodule

// ==== testbench/eil_ext_int_latch_tb.sv ====
// bench: register and pin scenarios for the external interrupt latch
`timescale 1ns/1ps
module eil_ext_int_latch_tb
  import eil_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, low = 1'b0, take = 1'b0, brk = 1'b0, we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  wire logic [7:0] rdat;
  wire logic irq, pu, pin_n, vfa, ev;
  int miscompares = 0, n_tests = 0;
  always #5 clk = ~clk;
  eil_src_model i_src (.ref_clk_i(clk), .pull_en_i(pu), .low_i(low), .irq_i(irq),
    .take_i(take), .pin_n_o(pin_n), .vfa_o(vfa));
  eil_ext_int_latch i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
    .int_pin_n_i(pin_n), .vector_fetch_ack_i(vfa), .break_state_i(brk), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat), .cpu_irq_req_o(irq),
    .pin_pullup_en_o(pu), .evt_irq_o(ev));
  task automatic chk(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ci(input int n, input logic e);
    cy(n);
    chk("irq", 8'(irq), 8'(e));
  endtask
  task automatic drv(input logic l, b, t);
    @(posedge clk);
    {low, brk, take} <= {l, b, t};
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    {we, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    {re, addr} <= {1'b1, a};
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk("rdata", rdat, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 8'h00);
    cy(1);
    chk("pullup", 8'(pu), 8'h01);
    drv(1, 0, 0);
    ci(5, 1);
    drv(0, 0, 0);
    ci(3, 1);
    rd(8'h00, 8'h08);
    drv(0, 0, 1);
    drv(0, 0, 0);
    ci(2, 0);
    wr(8'h00, 8'h02);
    drv(1, 0, 0);
    ci(5, 0);
    rd(8'h00, 8'h0a);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h00);
    drv(0, 0, 0);
    drv(1, 0, 0);
    ci(5, 1);
    wr(8'h00, 8'h05);
    ci(2, 1);
    drv(0, 0, 0);
    ci(4, 0);
    wr(8'h00, 8'h00);
    drv(1, 1, 0);
    cy(5);
    wr(8'h00, 8'h04);
    ci(1, 1);
    wr(8'h01, 8'h80);
    wr(8'h00, 8'h04);
    drv(1, 0, 0);
    ci(3, 0);
    rd(8'h02, 8'h03);
    wr(8'h03, 8'h01);
    cy(1);
    chk("evt_irq", 8'(ev), 8'h01);
    wr(8'h02, 8'h03);
    rd(8'h02, 8'h00);
    chk("evt_irq", 8'(ev), 8'h00);
    wr(8'h1e, 8'h01);
    cy(1);
    chk("pullup", 8'(pu), 8'h00);
    rd(8'h40, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    ci(1, 0);
    give_verdict;
  end
endmodule
